// File: scrc_clock_ratio.sv
// clock ratio configuration: straps, control registers, ratio decode, unit enables
//
// Summary of operation
// - core factor 1,1.5,2,2.5,3 from core field
// - bus clock is reference times 2..6
// - multiplier codes 0,1 reserved; 2,3 mean x2,x3
// - unit clocks off, bus, /2, /3; pci off/bus
// - local bus clock is lbc /2, /4, /8
// - lbc clock is 1x or 2x bus
// - ddr clock mode one doubles ddr clock
// - memory data rate twice memory clock
`default_nettype none
module scrc_clock_ratio #(
   parameter int unsigned REF_KHZ = 32'h0000_8235
) (
   input  wire  logic                          mclk_i,
   input  wire  logic                          resetn_i,
   input  wire  logic [scrc_pkg::ADDR_W-1:0]   avs_address_i,
   input  wire  logic                          avs_read_i,
   input  wire  logic                          avs_write_i,
   input  wire  logic [31:0]                   avs_writedata_i,
   input  wire  logic [3:0]                    avs_byteenable_i,
   output logic [31:0]                         avs_readdata_o,
   output logic                                avs_waitrequest_o,
   input  wire  logic [scrc_pkg::RCW_W-1:0]    rcw_strap_i,
   output logic                                rcw_valid_o,
   output logic [3:0]                          system_pll_mult_o,
   output logic [2:0]                          core_pll_half_o,
   output logic                                config_reserved_o,
   output logic [31:0]                         bus_freq_khz_o,
   output logic [31:0]                         core_freq_khz_o,
   output logic [1:0]                          lbc_mult_o,
   output logic [1:0]                          ddr_mult_o,
   output logic [2:0]                          mem_data_rate_mult_o,
   output logic [scrc_pkg::NUM_UNITS:0]        unit_clk_en_o,
   output logic                                local_bus_out_clock_o
);
   logic [1:0]                     rst_sync;
   logic                           rst_n;
   logic [scrc_pkg::RCW_W-1:0]     strap_s1, strap_s2, strap_s3;
   logic [1:0]                     settle;
   logic [scrc_pkg::RCW_W-1:0]     rcw;
   logic [8:0]                     clk_ctrl;
   logic [1:0]                     lb_ratio;
   logic                           ack;
   logic [3:0]                     sys_code;
   logic [2:0]                     core_code;
   logic                           sys_ok, core_ok;
   logic                           pci_en;
   wire  logic [scrc_pkg::NUM_UNITS-1:0] unit_pulse;
   logic [3:0]                     next_sys_mult;
   logic [2:0]                     next_core_half;
   logic [2:0]                     lb_period;
   logic [2:0]                     lb_cnt;
   logic                           wr_go;

   function automatic logic [1:0] unit_period(input logic [1:0] mode);
      case (mode)
         scrc_pkg::UM_DIV2: unit_period = 2'h2;
         scrc_pkg::UM_DIV3: unit_period = 2'h3;
         default:           unit_period = 2'h1;
      endcase
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      be_merge = r;
   endfunction

   // reset release through two flops
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // strap pins cross in; word taken once two late stages agree after settling
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         strap_s1 <= scrc_pkg::RCW_RESET;
         strap_s2 <= scrc_pkg::RCW_RESET;
         strap_s3 <= scrc_pkg::RCW_RESET;
      end else begin
         strap_s1 <= rcw_strap_i;
         strap_s2 <= strap_s1;
         strap_s3 <= strap_s2;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         settle      <= 2'h0;
         rcw         <= scrc_pkg::RCW_RESET;
         rcw_valid_o <= 1'b0;
      end else if (!rcw_valid_o) begin
         if (settle != scrc_pkg::STRAP_SETTLE) begin
            settle <= settle + 2'h1;
         end else if (strap_s2 == strap_s3) begin
            rcw         <= strap_s3;
            rcw_valid_o <= 1'b1;
         end
      end
   end

   // avalon slave: one wait cycle, data and write take effect at waitrequest low
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
   assign wr_go             = avs_write_i & ack;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         ack            <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end else begin
         ack <= (avs_read_i | avs_write_i) & ~ack;
         if (avs_read_i && !ack) begin
            case (avs_address_i)
               scrc_pkg::OFF_RCW:      avs_readdata_o <= {rcw_valid_o, 21'h0, rcw};
               scrc_pkg::OFF_CLK_CTRL: avs_readdata_o <= {23'h0, clk_ctrl};
               scrc_pkg::OFF_LB_RATIO: avs_readdata_o <= {30'h0, lb_ratio};
               scrc_pkg::OFF_BUS_FREQ: avs_readdata_o <= bus_freq_khz_o;
               scrc_pkg::OFF_CORE_FRQ: avs_readdata_o <= core_freq_khz_o;
               default:                avs_readdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // the strap word is read-only; limits on the chosen modes are software's
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         clk_ctrl <= scrc_pkg::CLK_CTRL_RESET;
      end else if (wr_go && avs_address_i == scrc_pkg::OFF_CLK_CTRL) begin
         clk_ctrl <= 9'(be_merge({23'h0, clk_ctrl}, avs_writedata_i, avs_byteenable_i));
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lb_ratio <= scrc_pkg::LB_RATIO_RESET;
      end else if (wr_go && avs_address_i == scrc_pkg::OFF_LB_RATIO) begin
         lb_ratio <= 2'(be_merge({30'h0, lb_ratio}, avs_writedata_i, avs_byteenable_i));
      end
   end

   // ratio decode
   assign sys_code  = rcw[scrc_pkg::SYS_MULT_LSB +: 4];
   assign core_code = rcw[scrc_pkg::CORE_RATIO_LSB +: 3];
   assign sys_ok    = (sys_code >= scrc_pkg::SYS_MULT_MIN) &&
                      (sys_code <= scrc_pkg::SYS_MULT_MAX);
   assign core_ok   = core_code <= scrc_pkg::CORE_CODE_MAX;
   assign next_sys_mult  = sys_ok ? sys_code : 4'h0;
   assign next_core_half = core_ok ? core_code + scrc_pkg::CORE_HALF_OFS : 3'h0;

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         system_pll_mult_o    <= 4'h0;
         core_pll_half_o      <= 3'h0;
         config_reserved_o    <= 1'b1;
         bus_freq_khz_o       <= 32'h0000_0000;
         core_freq_khz_o      <= 32'h0000_0000;
         lbc_mult_o           <= 2'h1;
         ddr_mult_o           <= 2'h1;
         mem_data_rate_mult_o <= 3'h2;
      end else begin
         system_pll_mult_o <= next_sys_mult;
         core_pll_half_o   <= next_core_half;
         config_reserved_o <= ~(sys_ok & core_ok);
         // frequencies assume the configurer respects the device limits
         bus_freq_khz_o    <= 32'(REF_KHZ * 32'(next_sys_mult));
         core_freq_khz_o   <= 32'((REF_KHZ * 32'(next_sys_mult) * 32'(next_core_half)) >> 1);
         lbc_mult_o        <= rcw[scrc_pkg::LB_MODE_BIT] ? 2'h2 : 2'h1;
         ddr_mult_o        <= rcw[scrc_pkg::DDR_MODE_BIT] ? 2'h2 : 2'h1;
         mem_data_rate_mult_o <= rcw[scrc_pkg::DDR_MODE_BIT] ? 3'h4 : 3'h2;
      end
   end

   // unit clock enables, one bus-clock pulse per unit period of 1, 2 or 3 bus clocks, none when off
   genvar gi;
   generate
      for (gi = 0; gi < scrc_pkg::NUM_UNITS; gi++) begin : g_unit
         logic [1:0] cnt;
         logic [1:0] mode;
         logic       en;
         assign mode = clk_ctrl[2*gi +: 2];
         always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
               cnt <= 2'h0;
               en  <= 1'b0;
            end else begin
               cnt <= (cnt + 2'h1 >= unit_period(mode)) ? 2'h0 : cnt + 2'h1;
               en  <= (mode != scrc_pkg::UM_OFF) && (cnt == 2'h0);
            end
         end
         assign unit_pulse[gi] = en;
      end
   endgenerate

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pci_en <= 1'b0;
      end else begin
         pci_en <= clk_ctrl[scrc_pkg::PCI_BIT];
      end
   end
   // one driver for the whole vector, every bit still straight from a flop
   assign unit_clk_en_o = {pci_en, unit_pulse};

   // local bus clock: lbc divide over the 2x lbc speed-up, in bus cycles
   always_comb begin
      case (lb_ratio)
         scrc_pkg::LBD_2: lb_period = rcw[scrc_pkg::LB_MODE_BIT] ? 3'h1 : 3'h2;
         scrc_pkg::LBD_4: lb_period = rcw[scrc_pkg::LB_MODE_BIT] ? 3'h2 : 3'h4;
         default:         lb_period = rcw[scrc_pkg::LB_MODE_BIT] ? 3'h4 : 3'h0; // wraps as 8
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         lb_cnt                <= 3'h0;
         local_bus_out_clock_o <= 1'b0;
      end else begin
         lb_cnt <= (lb_cnt + 3'h1 == lb_period) ? 3'h0 : lb_cnt + 3'h1;
         local_bus_out_clock_o <= (lb_cnt == 3'h0);
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n);

   AST_CORE_FACTOR: assert property (##1 rcw_valid_o && core_pll_half_o != 3'h0 |->
      core_pll_half_o >= 3'h2 && core_pll_half_o <= 3'h6)
      else $error("core factor out of range");
   AST_SYS_MULT: assert property (sys_ok && $stable(rcw) |=>
      system_pll_mult_o == $past(sys_code) && !config_reserved_o || !core_ok)
      else $error("system multiplier not taken");
   AST_MULT_RESERVED: assert property (sys_code < 4'h2 |=> config_reserved_o &&
      system_pll_mult_o == 4'h0 && bus_freq_khz_o == 32'h0000_0000)
      else $error("reserved multiplier not flagged");
   AST_UNIT_DIV2: assert property (unit_clk_en_o[0] && clk_ctrl[1:0] == 2'h2 &&
      $stable(clk_ctrl) ##1 $stable(clk_ctrl) |-> !unit_clk_en_o[0] ##1 unit_clk_en_o[0])
      else $error("unit divide by two wrong");
   AST_UNIT_OFF: assert property (clk_ctrl[3:2] == 2'h0 ##1 clk_ctrl[3:2] == 2'h0 |->
      !unit_clk_en_o[1])
      else $error("unit clock running while off");
   AST_LB_DIV8: assert property (local_bus_out_clock_o && lb_ratio == 2'h2 &&
      !rcw[8] && $stable(lb_ratio) |=> !local_bus_out_clock_o[*7] ##1 local_bus_out_clock_o)
      else $error("local bus divide by eight wrong");
   AST_LBC_MODE: assert property (##1 $stable(rcw) |->
      lbc_mult_o == ($past(rcw[8]) ? 2'h2 : 2'h1))
      else $error("lbc mode not applied");
   AST_DDR_RATE: assert property (##1 $stable(rcw) && $past(rcw[9]) |->
      ddr_mult_o == 2'h2 && mem_data_rate_mult_o == 3'h4)
      else $error("ddr mode not applied");
   AST_MEM_RATE: assert property (mem_data_rate_mult_o == 3'(ddr_mult_o) << 1)
      else $error("memory data rate not twice clock");
   AST_CORE_FREQ: assert property (##1 $stable(rcw) |->
      core_freq_khz_o == 32'((bus_freq_khz_o * 32'(core_pll_half_o)) >> 1))
      else $error("core frequency mismatch");
   AST_BUS_ANSWER: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o)
      else $error("bus answer late");

   COV_STRAP: cover property (!rcw_valid_o ##1 rcw_valid_o);
   COV_DIV3: cover property (clk_ctrl[5:4] == 2'h3 && unit_clk_en_o[2]);
   COV_LB2X: cover property (rcw[8] && local_bus_out_clock_o);
   COV_WRITE: cover property (wr_go && avs_address_i == scrc_pkg::OFF_CLK_CTRL);
endmodule
`default_nettype wire

// File: scrc_pkg.sv
// constants for the clock ratio configuration block
`default_nettype none
package scrc_pkg;
   localparam int unsigned ADDR_W      = 5;
   localparam int unsigned RCW_W       = 10;
   localparam int unsigned NUM_UNITS   = 4;
   localparam int unsigned SYNC_STAGES = 3;
   // byte offsets, one aligned word each
   localparam logic [4:0] OFF_RCW      = 5'h00;
   localparam logic [4:0] OFF_CLK_CTRL = 5'h04;
   localparam logic [4:0] OFF_LB_RATIO = 5'h08;
   localparam logic [4:0] OFF_BUS_FREQ = 5'h0C;
   localparam logic [4:0] OFF_CORE_FRQ = 5'h10;
   // reset config word fields
   localparam int unsigned SYS_MULT_LSB   = 0;
   localparam int unsigned CORE_RATIO_LSB = 4;
   localparam int unsigned LB_MODE_BIT    = 8;
   localparam int unsigned DDR_MODE_BIT   = 9;
   localparam logic [RCW_W-1:0] RCW_RESET = 10'h000;
   // system clock control fields: two bits per unit at 2*i, pci enable above
   localparam int unsigned PCI_BIT      = 8;
   localparam logic [8:0]  CLK_CTRL_RESET = 9'h155;
   localparam int unsigned LB_DIV_LSB     = 0;
   localparam logic [1:0]  LB_RATIO_RESET = 2'h0;
   // unit clock modes
   localparam logic [1:0] UM_OFF  = 2'h0;
   localparam logic [1:0] UM_BUS  = 2'h1;
   localparam logic [1:0] UM_DIV2 = 2'h2;
   localparam logic [1:0] UM_DIV3 = 2'h3;
   // local bus divider codes, 2'h3 behaves as /8
   localparam logic [1:0] LBD_2 = 2'h0;
   localparam logic [1:0] LBD_4 = 2'h1;
   localparam logic [1:0] LBD_8 = 2'h2;
   // system pll multiplier range
   localparam logic [3:0] SYS_MULT_MIN = 4'h2;
   localparam logic [3:0] SYS_MULT_MAX = 4'h6;
   // core pll codes 0..4 give twice the factor 2..6
   localparam logic [2:0] CORE_CODE_MAX = 3'h4;
   localparam logic [2:0] CORE_HALF_OFS = 3'h2;
   localparam logic [1:0] STRAP_SETTLE  = 2'h3;
endpackage
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the clock ratio configuration block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // low reference: multipliers up to six keep bus, core and local bus in limits
   // vco divider, usb reference and gigabit use are board matters; none is claimed
   localparam int unsigned REF = 32'h0000_61A8;
   logic        mclk_i   = 1'b0;
   logic        resetn_i = 1'b0;
   logic [4:0]  adr      = 5'h00;
   logic        rd       = 1'b0;
   logic        wr       = 1'b0;
   logic [31:0] wdata    = 32'h0;
   logic [3:0]  be       = 4'hF;
   logic [9:0]  strap    = 10'h223;
   logic [31:0] rdata;
   logic        wait_req;
   logic        vld;
   logic [3:0]  spm;
   logic [2:0]  chf;
   logic        rsv;
   logic [31:0] bfq;
   logic [31:0] cfq;
   logic [1:0]  lbm;
   logic [1:0]  ddm;
   logic [2:0]  mdr;
   logic [4:0]  uen;
   logic        lbo;
   logic [31:0] cnt [0:5];
   int          fails = 0;
   int          samples_checked = 0;

   scrc_clock_ratio #(.REF_KHZ(REF)) dut (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .rcw_strap_i(strap),
      .rcw_valid_o(vld), .system_pll_mult_o(spm), .core_pll_half_o(chf),
      .config_reserved_o(rsv), .bus_freq_khz_o(bfq), .core_freq_khz_o(cfq),
      .lbc_mult_o(lbm), .ddr_mult_o(ddm), .mem_data_rate_mult_o(mdr),
      .unit_clk_en_o(uen), .local_bus_out_clock_o(lbo));

   always #50 mclk_i = ~mclk_i;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // straps are read only once, so every new strap word needs a fresh reset
   task automatic do_reset(input logic [9:0] s);
      int n;
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      strap <= s;
      repeat (12) @(posedge mclk_i);
      chk({rsv, uen}, 32'h20);
      resetn_i <= 1'b1;
      n = 0;
      while (vld !== 1'b1 && n < 40) begin
         @(posedge mclk_i);
         n++;
      end
      if (n == 40) chk(32'h0, 32'h1);
      repeat (2) @(posedge mclk_i);
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      int n;
      @(posedge mclk_i);
      rd <= ~w;
      wr <= w;
      adr <= a;
      wdata <= d;
      be <= b;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (wait_req !== 1'b0 && n < 20);
      q = rdata;
      if (n == 20) chk(32'h0, 32'h1);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // 24 is a multiple of every period, so counts come out exact
   task automatic count24();
      for (int i = 0; i < 6; i++) cnt[i] = 32'h0;
      repeat (24) begin
         @(posedge mclk_i);
         for (int i = 0; i < 5; i++) if (uen[i] === 1'b1) cnt[i] = cnt[i] + 1;
         if (lbo === 1'b1) cnt[5] = cnt[5] + 1;
      end
   endtask

   task automatic t_strap();
      for (int s = 0; s < 8; s++) begin
         do_reset(10'h220 | 10'(s));
         chk(spm, (s >= 2 && s <= 6) ? 32'(s) : 32'h0);
         chk(rsv, (s >= 2 && s <= 6) ? 32'h0 : 32'h1);
         if (s >= 2 && s <= 6) chk(bfq, 32'(REF * s));
         chk({ddm, mdr}, 32'h14);
      end
      for (int c = 0; c < 8; c++) begin
         do_reset(10'h002 | 10'(c << 4));
         chk(chf, (c <= 4) ? 32'(c + 2) : 32'h0);
         chk(rsv, (c <= 4) ? 32'h0 : 32'h1);
         if (c <= 4) chk(cfq, 32'(REF * 2 * (c + 2) / 2));
         chk({ddm, mdr}, 32'h0A);
      end
      $display("test strap decode done");
   endtask

   task automatic t_map();
      logic [31:0] q;
      logic [8:0]  v [2] = '{9'h131, 9'h0E6};
      do_reset(10'h223);
      bus(1'b0, 5'h00, 32'h0, 4'hF, q);
      chk(q, 32'h8000_0223);
      bus(1'b1, 5'h00, 32'h0, 4'hF, q);
      bus(1'b1, 5'h0C, 32'h0, 4'hF, q);
      bus(1'b0, 5'h00, 32'h0, 4'hF, q);
      chk(q, 32'h8000_0223);
      bus(1'b0, 5'h0C, 32'h0, 4'hF, q);
      chk(q, 32'(REF * 3));
      bus(1'b0, 5'h10, 32'h0, 4'hF, q);
      chk(q, 32'(REF * 3 * 2));
      bus(1'b0, 5'h14, 32'h0, 4'hF, q);
      chk(q, 32'h0);
      bus(1'b0, 5'h04, 32'h0, 4'hF, q);
      chk(q, 32'h155);
      for (int k = 0; k < 2; k++) begin
         // security and usb never run above the bus clock
         bus(1'b1, 5'h04, 32'(v[k]), 4'hF, q);
         repeat (4) @(posedge mclk_i);
         count24();
         for (int u = 0; u < 4; u++)
            chk(cnt[u], (v[k][2*u +: 2] == 2'h0) ? 32'h0 : 32'(24 / v[k][2*u +: 2]));
         chk(cnt[4], v[k][8] ? 32'h18 : 32'h0);
      end
      // only lane one written: low byte must survive the zero data
      bus(1'b1, 5'h04, 32'hFFFF_FF00, 4'h2, q);
      bus(1'b0, 5'h04, 32'h0, 4'hF, q);
      chk(q, 32'h1E6);
      $display("test register map and unit clocks done");
   endtask

   task automatic t_lbus();
      logic [31:0] q;
      for (int m = 0; m < 2; m++) begin
         do_reset(10'h222 | 10'(m << 8));
         chk(lbm, 32'(m + 1));
         bus(1'b0, 5'h08, 32'h0, 4'hF, q);
         chk(q, 32'h0);
         for (int d = 0; d < 4; d++) begin
            bus(1'b1, 5'h08, 32'(d), 4'hF, q);
            repeat (10) @(posedge mclk_i);
            count24();
            chk(cnt[5], 32'(24 * (m + 1) / (2 << ((d == 3) ? 2 : d))));
         end
      end
      $display("test local bus clock done");
   endtask

   initial begin
      t_strap();
      t_map();
      t_lbus();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      $display("[FAIL] %0t ns: watchdog expired", $time);
      finish_test();
   end
endmodule
`default_nettype wire
